// ---- verilog/uart_cmd_regs.vh ----
// Function
// R1 - 115200 baud, start bit, 8 data bits LSB first, no parity, one stop, idle high
// R2 - Received command bytes wait in an eight byte first-in first-out store
// R3 - Reception runs in every running mode and every output pin mode
// R4 - Start bit read as 1 at its midpoint flags noise and drops the byte
// R5 - Stop bit missing at its sampling instant flags framing and drops the byte
// R6 - Byte arriving while the store is full flags overrun and is discarded
// R7 - Noise, framing or overrun also discards any pending address byte; code lets a byte decoded in the fault's cycle still use or set it
// R8 - Top bit 1 means address byte, 0 means parameter byte; check on parameter
// R9 - Parameter byte with no pending address raises a syntax error
// R10 - Parameter byte after an unusable address raises a syntax error
// R11 - Unconfigurable parameter value after a valid address raises a syntax error
// R12 - Syntax error discards both address and parameter, applying nothing
// R13 - Back to back address bytes raise no error; only the last stays pending
// R14 - Replies go out on the output pin only in its serial transmit mode
// R15 - A command selects one of three output pin modes
// R16 - Output pin starts in plain digital level mode
// R17 - Each error type gives a one-cycle indication
`ifndef UART_CMD_REGS_VH
`define UART_CMD_REGS_VH

// ****************************************
// Line timing
// ****************************************
`define UCR_CLK_HZ        250000000
`define UCR_BAUD_RATE     115200
`define UCR_BIT_CYCLES    (`UCR_CLK_HZ / `UCR_BAUD_RATE)
`define UCR_HALF_CYCLES   (`UCR_BIT_CYCLES / 2)
`define UCR_DATA_BITS     8
`define UCR_FIFO_DEPTH    8
`define UCR_TX_LAST       4'h9

// ****************************************
// Command layout
// ****************************************
`define UCR_ADDR_FLAG_BIT 7
`define UCR_ADDR_MODE     7'h00
`define UCR_ADDR_READ     7'h01
`define UCR_ADDR_SETTING  7'h02
`define UCR_PARAM_LIMIT   7'h03

// ****************************************
// Output pin modes
// ****************************************
`define UCR_MODE_DIGITAL  2'h0
`define UCR_MODE_PWM      2'h1
`define UCR_MODE_UART     2'h2

// ****************************************
// Read selectors
// ****************************************
`define UCR_READ_DETECT   2'h0
`define UCR_READ_MODE     2'h1
`define UCR_READ_SETTING  2'h2

`endif

// ---- verilog/uart_command_receiver.v ----
`timescale 1ns/1ns
`include "uart_cmd_regs.vh"

// ****************************************
// Byte store
// ****************************************
module cmd_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             i_sys_clk,
    input  wire             i_rst,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    function [AW-1:0] ptr_inc;
        input [AW-1:0] p;
        begin
            if (p == DEPTH - 1)
                ptr_inc = {AW{1'b0}};
            else
                ptr_inc = p + 1'b1;
        end
    endfunction

    assign o_in_ready  = (count_reg != DEPTH);
    assign o_out_valid = (count_reg != {(AW+1){1'b0}});
    assign o_out_data  = mem[rd_ptr_reg];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always @(posedge i_sys_clk) begin
        if (push)
            mem[wr_ptr_reg] <= i_in_data;
    end

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            if (pop)
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// ****************************************
// Command receiver
// ****************************************
module uart_command_receiver #(
    parameter BIT_CYCLES  = `UCR_BIT_CYCLES,
    parameter HALF_CYCLES = `UCR_HALF_CYCLES,
    parameter FIFO_DEPTH  = `UCR_FIFO_DEPTH
) (
    input  wire       i_sys_clk,
    input  wire       i_rst,
    input  wire       i_uart_rx,
    input  wire       i_detect_level,
    input  wire       i_pwm_level,
    output reg        o_multimode_output_pin,
    output reg  [1:0] o_pin_mode,
    output reg  [6:0] o_setting_value,
    output reg        o_setting_strobe,
    output reg        o_noise_err,
    output reg        o_frame_err,
    output reg        o_overrun_err,
    output reg        o_syntax_err
);
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_START = 3'h1;
    localparam [2:0] S_DATA  = 3'h2;
    localparam [2:0] S_STOP  = 3'h3;
    localparam [2:0] S_BREAK = 3'h4;
    localparam integer BIT_LOAD_I  = BIT_CYCLES - 1;
    localparam integer HALF_LOAD_I = HALF_CYCLES - 1;
    localparam integer LAST_BIT_I  = `UCR_DATA_BITS - 1;
    localparam [11:0]  BIT_LOAD    = BIT_LOAD_I[11:0];
    localparam [11:0]  HALF_LOAD   = HALF_LOAD_I[11:0];
    localparam [2:0]   LAST_BIT    = LAST_BIT_I[2:0];

    reg        rx_meta_reg;
    reg        rx_sync_reg;
    reg [2:0]  state_reg;
    reg [11:0] baud_cnt_reg;
    reg [2:0]  bit_idx_reg;
    reg [7:0]  shift_reg;
    reg        byte_valid_reg;
    reg [7:0]  byte_reg;
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire       cmd_ready;
    wire       cmd_pop;
    reg        pend_valid_reg;
    reg [6:0]  pend_addr_reg;
    reg        tx_busy_reg;
    reg [9:0]  tx_shift_reg;
    reg [11:0] tx_cnt_reg;
    reg [3:0]  tx_bits_reg;
    reg [7:0]  reply;
    wire       rx_fault;

    // ****************************************
    // Receive line
    // ****************************************
    // Nothing here looks at running mode or pin mode, so commands always land
    always @(posedge i_sys_clk) begin // R3
        if (i_rst) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= i_uart_rx;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_reg      <= S_IDLE;
            baud_cnt_reg   <= 12'h000;
            bit_idx_reg    <= 3'h0;
            shift_reg      <= 8'h00;
            byte_valid_reg <= 1'b0;
            byte_reg       <= 8'h00;
            o_noise_err    <= 1'b0;
            o_frame_err    <= 1'b0;
        end else begin
            byte_valid_reg <= 1'b0;
            o_noise_err    <= 1'b0;
            o_frame_err    <= 1'b0;
            if (baud_cnt_reg != 12'h000)
                baud_cnt_reg <= baud_cnt_reg - 1'b1;
            case (state_reg)
                S_IDLE: begin
                    if (!rx_sync_reg) begin
                        state_reg    <= S_START;
                        baud_cnt_reg <= HALF_LOAD;
                    end
                end
                S_START: begin
                    if (baud_cnt_reg == 12'h000) begin
                        if (rx_sync_reg) begin
                            o_noise_err <= 1'b1; // R4 R17
                            state_reg   <= S_IDLE;
                        end else begin
                            state_reg    <= S_DATA;
                            baud_cnt_reg <= BIT_LOAD;
                            bit_idx_reg  <= 3'h0;
                        end
                    end
                end
                S_DATA: begin
                    if (baud_cnt_reg == 12'h000) begin
                        shift_reg    <= {rx_sync_reg, shift_reg[7:1]}; // R1
                        bit_idx_reg  <= bit_idx_reg + 1'b1;
                        baud_cnt_reg <= BIT_LOAD;
                        if (bit_idx_reg == LAST_BIT)
                            state_reg <= S_STOP;
                    end
                end
                S_STOP: begin
                    if (baud_cnt_reg == 12'h000) begin
                        if (rx_sync_reg) begin
                            byte_valid_reg <= 1'b1;
                            byte_reg       <= shift_reg;
                            state_reg      <= S_IDLE;
                        end else begin
                            o_frame_err <= 1'b1; // R5 R17
                            state_reg   <= S_BREAK;
                        end
                    end
                end
                S_BREAK: begin
                    // A held-low line must go high first, or it would fake a start
                    if (rx_sync_reg)
                        state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_rst)
            o_overrun_err <= 1'b0;
        else
            o_overrun_err <= byte_valid_reg & ~fifo_in_ready; // R6 R17
    end

    // ****************************************
    // Byte store
    // ****************************************
    cmd_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst),
        .i_in_valid  (byte_valid_reg), // R2 R6
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (byte_reg),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (cmd_ready),
        .o_out_data  (fifo_out_data)
    );

    // ****************************************
    // Command interpreter
    // ****************************************
    // A reply in flight stalls decoding; bytes arriving meanwhile wait in the store
    assign cmd_ready = ~tx_busy_reg;
    assign cmd_pop   = fifo_out_valid & cmd_ready;
    assign rx_fault  = o_noise_err | o_frame_err | o_overrun_err;

    always @* begin
        case (fifo_out_data[1:0])
            `UCR_READ_DETECT:  reply = {7'h00, i_detect_level};
            `UCR_READ_MODE:    reply = {6'h00, o_pin_mode};
            default:           reply = {1'b0, o_setting_value};
        endcase
    end

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            pend_valid_reg   <= 1'b0;
            pend_addr_reg    <= 7'h00;
            o_pin_mode       <= `UCR_MODE_DIGITAL; // R16
            o_setting_value  <= 7'h00;
            o_setting_strobe <= 1'b0;
            o_syntax_err     <= 1'b0;
            tx_busy_reg      <= 1'b0;
            tx_shift_reg     <= 10'h3ff;
            tx_cnt_reg       <= 12'h000;
            tx_bits_reg      <= 4'h0;
        end else begin
            o_setting_strobe <= 1'b0;
            o_syntax_err     <= 1'b0;
            if (rx_fault)
                pend_valid_reg <= 1'b0; // R7
            if (cmd_pop) begin
                if (fifo_out_data[`UCR_ADDR_FLAG_BIT]) begin
                    pend_valid_reg <= 1'b1; // R8 R13
                    pend_addr_reg  <= fifo_out_data[6:0];
                end else begin
                    pend_valid_reg <= 1'b0; // R12
                    if (!pend_valid_reg) begin
                        o_syntax_err <= 1'b1; // R9 R17
                    end else begin
                        case (pend_addr_reg)
                            `UCR_ADDR_MODE: begin
                                if (fifo_out_data[6:0] < `UCR_PARAM_LIMIT)
                                    o_pin_mode <= fifo_out_data[1:0]; // R15
                                else
                                    o_syntax_err <= 1'b1; // R11
                            end
                            `UCR_ADDR_READ: begin
                                if (fifo_out_data[6:0] >= `UCR_PARAM_LIMIT) begin
                                    o_syntax_err <= 1'b1; // R11
                                end else if (o_pin_mode == `UCR_MODE_UART) begin
                                    tx_busy_reg  <= 1'b1; // R14
                                    tx_shift_reg <= {1'b1, reply, 1'b0};
                                    tx_cnt_reg   <= BIT_LOAD;
                                    tx_bits_reg  <= 4'h0;
                                end
                            end
                            `UCR_ADDR_SETTING: begin
                                o_setting_value  <= fifo_out_data[6:0];
                                o_setting_strobe <= 1'b1;
                            end
                            default: begin
                                o_syntax_err <= 1'b1; // R10
                            end
                        endcase
                    end
                end
            end
            // ****************************************
            // Reply transmitter
            // ****************************************
            if (tx_busy_reg) begin
                if (tx_cnt_reg != 12'h000) begin
                    tx_cnt_reg <= tx_cnt_reg - 1'b1;
                end else begin
                    tx_shift_reg <= {1'b1, tx_shift_reg[9:1]}; // R1
                    tx_cnt_reg   <= BIT_LOAD;
                    tx_bits_reg  <= tx_bits_reg + 1'b1;
                    if (tx_bits_reg == `UCR_TX_LAST)
                        tx_busy_reg <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Output pin
    // ****************************************
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_multimode_output_pin <= 1'b0;
        end else begin
            case (o_pin_mode)
                `UCR_MODE_PWM:  o_multimode_output_pin <= i_pwm_level;
                `UCR_MODE_UART: o_multimode_output_pin <= tx_shift_reg[0]; // R14
                default:        o_multimode_output_pin <= i_detect_level; // R16
            endcase
        end
    end
endmodule

// ---- test/uart_command_receiver_assertions.sv ----
`timescale 1ns/1ns
module ucr_checker #(
    parameter BIT_CYCLES = 2170
) (
    input wire       i_sys_clk,
    input wire       i_rst,
    input wire       i_uart_rx,
    input wire       i_detect_level,
    input wire       i_pwm_level,
    input wire       o_multimode_output_pin,
    input wire [1:0] o_pin_mode,
    input wire [6:0] o_setting_value,
    input wire       o_setting_strobe,
    input wire       o_noise_err,
    input wire       o_frame_err,
    input wire       o_overrun_err,
    input wire       o_syntax_err
);
    // ****************************************
    // Transmit low-time counter
    // ****************************************
    // A frame holds the line low for nine bit times at most
    logic [15:0] low_cnt;
    always @(posedge i_sys_clk) begin
        if (i_rst || o_multimode_output_pin || o_pin_mode != 2'h2) low_cnt <= 16'h0;
        else low_cnt <= low_cnt + 16'h1;
    end
    default clocking dc @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    noise_pulse_a: assert property (o_noise_err |=> !o_noise_err)
        else $error("noise pulse too long");
    frame_pulse_a: assert property (o_frame_err |=> !o_frame_err)
        else $error("framing pulse too long");
    overrun_pulse_a: assert property (o_overrun_err |=> !o_overrun_err)
        else $error("overrun pulse too long");
    syntax_pulse_a: assert property (o_syntax_err |=> !o_syntax_err)
        else $error("syntax pulse too long");
    noise_cause_a: assert property (o_noise_err |-> $past(i_uart_rx, 3))
        else $error("noise flagged on a low start bit");
    frame_cause_a: assert property (o_frame_err |-> !$past(i_uart_rx, 3))
        else $error("framing flagged on a high stop bit");
    mode_legal_a: assert property (o_pin_mode != 2'h3)
        else $error("undefined pin mode");
    digital_follow_a: assert property ((o_pin_mode == 2'h0 && $past(o_pin_mode) == 2'h0
        && !$past(i_rst)) |-> o_multimode_output_pin == $past(i_detect_level))
        else $error("pin does not follow detection");
    pwm_follow_a: assert property ((o_pin_mode == 2'h1 && $past(o_pin_mode) == 2'h1
        && !$past(i_rst)) |-> o_multimode_output_pin == $past(i_pwm_level))
        else $error("pin does not follow pwm");
    tx_low_a: assert property (low_cnt <= 9 * BIT_CYCLES + 1)
        else $error("transmit line low too long");
    cover property (o_noise_err);
    cover property (o_frame_err);
    cover property (o_pin_mode == 2'h2 && !o_multimode_output_pin);
endmodule

// ---- test/host_uart.sv ----
`timescale 1ns/1ns
module host_uart #(
    parameter BIT_CYCLES = 16
) (
    input  wire  i_sys_clk,
    input  wire  i_pin,
    output logic o_rx
);
    initial o_rx = 1'b1;
    task bit_time(input logic v);
        o_rx = v;
        repeat (BIT_CYCLES) @(posedge i_sys_clk);
        #1;
    endtask
    // Kind 0 good byte, 1 short glitch, 2 stop bit held low
    task send(input logic [7:0] b, input logic [1:0] k);
        int i;
        if (k == 2'h1) begin
            o_rx = 1'b0;
            repeat (2) @(posedge i_sys_clk);
            #1 o_rx = 1'b1;
            repeat (BIT_CYCLES * 10) @(posedge i_sys_clk);
            #1;
        end else begin
            bit_time(1'b0);
            for (i = 0; i < 8; i++) bit_time(b[i]);
            bit_time(k != 2'h2);
            if (k == 2'h2) bit_time(1'b1);
        end
    endtask
    // Bounded wait, so a silent pin returns ok low instead of hanging
    task get_reply(output logic [7:0] d, output logic ok);
        int i;
        int n;
        n = 0;
        d = 8'h00;
        while (i_pin !== 1'b0 && n < 40 * BIT_CYCLES) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        repeat (BIT_CYCLES / 2) @(posedge i_sys_clk);
        #1 ok = (i_pin === 1'b0) && (n < 40 * BIT_CYCLES);
        for (i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge i_sys_clk);
            #1 d[i] = i_pin;
        end
        repeat (BIT_CYCLES) @(posedge i_sys_clk);
        #1 ok = ok && (i_pin === 1'b1);
    endtask
endmodule

// ---- test/tb_uart_command_receiver.sv ----
`timescale 1ns/1ns
module tb_uart_command_receiver;
    localparam BC = 16;
    logic       i_sys_clk = 1'b0;
    logic       i_rst = 1'b1;
    wire        i_uart_rx;
    logic       i_detect_level = 1'b0;
    logic       i_pwm_level = 1'b0;
    wire        o_multimode_output_pin;
    wire  [1:0] o_pin_mode;
    wire  [6:0] o_setting_value;
    wire        o_setting_strobe;
    wire        o_noise_err;
    wire        o_frame_err;
    wire        o_overrun_err;
    wire        o_syntax_err;
    int         n_errors = 0;
    int         n_tests = 0;
    int         cyc = 0;
    logic [9:0] exp_q[$];
    logic [1:0] mode_q = 2'h0;
    logic [7:0] r;
    logic       ok;
    logic [6:0] p;
    uart_command_receiver #(.BIT_CYCLES(BC), .HALF_CYCLES(BC / 2)) DUT (
        .i_sys_clk              (i_sys_clk),
        .i_rst                  (i_rst),
        .i_uart_rx              (i_uart_rx),
        .i_detect_level         (i_detect_level),
        .i_pwm_level            (i_pwm_level),
        .o_multimode_output_pin (o_multimode_output_pin),
        .o_pin_mode             (o_pin_mode),
        .o_setting_value        (o_setting_value),
        .o_setting_strobe       (o_setting_strobe),
        .o_noise_err            (o_noise_err),
        .o_frame_err            (o_frame_err),
        .o_overrun_err          (o_overrun_err),
        .o_syntax_err           (o_syntax_err)
    );
    host_uart #(.BIT_CYCLES(BC)) host (.i_sys_clk(i_sys_clk),
        .i_pin(o_multimode_output_pin), .o_rx(i_uart_rx));
    initial forever #2 i_sys_clk = ~i_sys_clk;
    // ****************************************
    // Checking
    // ****************************************
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
            n_errors++;
        end
    endtask
    task ev(input logic [9:0] g);
        if (exp_q.size() == 0) chk({22'h0, g}, 32'hffffffff);
        else chk({22'h0, g}, {22'h0, exp_q.pop_front()});
    endtask
    task tx(input logic [7:0] b, input logic [1:0] k, input logic [9:0] e);
        if (e !== 10'h000) exp_q.push_back(e);
        host.send(b, k);
    endtask
    // Read command with a selector; the reply is checked only when one is due
    task rd(input logic [7:0] s, input logic [7:0] e, input logic ok_e);
        tx(8'h81, 2'h0, 10'h0);
        fork
            tx(s, 2'h0, 10'h0);
            host.get_reply(r, ok);
        join
        chk(ok, ok_e);
        if (ok_e) chk(r, e);
    endtask
    task give_verdict;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Events: 1 noise, 2 framing, 3 overrun, 4 syntax, 5 setting, 6 mode
    always @(posedge i_sys_clk) begin
        if (i_rst) mode_q <= 2'h0;
        else begin
            if (o_noise_err) ev(10'h080);
            if (o_frame_err) ev(10'h100);
            if (o_overrun_err) ev(10'h180);
            if (o_syntax_err) ev(10'h200);
            if (o_setting_strobe) ev({3'h5, o_setting_value});
            if (o_pin_mode !== mode_q) ev({8'hc0, o_pin_mode});
            mode_q <= o_pin_mode;
        end
    end
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict;
        end
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        void'($urandom(1));
        repeat (4) @(posedge i_sys_clk);
        #1 i_rst = 1'b0;
        chk(o_pin_mode, 2'h0);
        repeat (8) begin
            @(posedge i_sys_clk);
            #1 i_detect_level = 1'($urandom);
            @(posedge i_sys_clk);
            #1 chk(o_multimode_output_pin, i_detect_level);
        end
        $display("test digital done");
        p = 7'($urandom);
        tx(8'h82, 2'h0, 10'h0);
        tx({1'b0, p}, 2'h0, {3'h5, p});
        tx(8'h15, 2'h0, 10'h200);
        tx(8'h85, 2'h0, 10'h0);
        tx(8'h01, 2'h0, 10'h200);
        tx(8'h80, 2'h0, 10'h0);
        tx(8'h03, 2'h0, 10'h200);
        tx(8'h05, 2'h0, 10'h200);
        tx(8'h85, 2'h0, 10'h0);
        tx(8'h80, 2'h0, 10'h0);
        tx(8'h82, 2'h0, 10'h0);
        tx(8'h11, 2'h0, 10'h291);
        $display("test syntax done");
        tx(8'h82, 2'h0, 10'h0);
        tx(8'h00, 2'h1, 10'h080);
        tx(8'h22, 2'h0, 10'h200);
        tx(8'h82, 2'h0, 10'h0);
        tx(8'h00, 2'h2, 10'h100);
        tx(8'h22, 2'h0, 10'h200);
        $display("test line errors done");
        tx(8'h80, 2'h0, 10'h0);
        tx(8'h02, 2'h0, 10'h302);
        repeat (4) @(posedge i_sys_clk);
        #1 chk(o_multimode_output_pin, 1'b1);
        rd(8'h02, 8'h11, 1'b1);
        rd(8'h01, 8'h02, 1'b1);
        i_detect_level = 1'($urandom);
        rd(8'h00, {7'h00, i_detect_level}, 1'b1);
        p = 7'($urandom);
        tx(8'h82, 2'h0, 10'h0);
        tx({1'b0, p}, 2'h0, {3'h5, p});
        tx(8'h80, 2'h0, 10'h0);
        tx(8'h01, 2'h0, 10'h301);
        repeat (8) begin
            @(posedge i_sys_clk);
            #1 i_pwm_level = 1'($urandom);
            @(posedge i_sys_clk);
            #1 chk(o_multimode_output_pin, i_pwm_level);
        end
        $display("test modes done");
        i_rst = 1'b1;
        repeat (2) @(posedge i_sys_clk);
        #1 i_rst = 1'b0;
        chk(o_pin_mode, 2'h0);
        rd(8'h00, 8'h00, 1'b0);
        $display("test reset done");
        chk(exp_q.size(), 0);
        give_verdict;
    end
endmodule
bind uart_command_receiver ucr_checker #(.BIT_CYCLES(BIT_CYCLES)) chk_u (
    .i_sys_clk              (i_sys_clk),
    .i_rst                  (i_rst),
    .i_uart_rx              (i_uart_rx),
    .i_detect_level         (i_detect_level),
    .i_pwm_level            (i_pwm_level),
    .o_multimode_output_pin (o_multimode_output_pin),
    .o_pin_mode             (o_pin_mode),
    .o_setting_value        (o_setting_value),
    .o_setting_strobe       (o_setting_strobe),
    .o_noise_err            (o_noise_err),
    .o_frame_err            (o_frame_err),
    .o_overrun_err          (o_overrun_err),
    .o_syntax_err           (o_syntax_err)
);
